// ==== src/fifp_pkg.sv ====
`default_nettype none
// ============================================================
// Shared constants and carriers of the fast interrupt block
package fifp_pkg;
  // Block base on the bus; the fast vector word sits at base+0x104
  localparam logic [31:0] BASE_ADDR = 32'hffff_f000;
  // Byte offsets inside the 4 KB window
  localparam logic [11:0] OFF_SMR0 = 12'h000;
  localparam logic [11:0] OFF_SVR0 = 12'h080;
  localparam logic [11:0] OFF_IVR = 12'h100;
  localparam logic [11:0] OFF_FVR = 12'h104;
  localparam logic [11:0] OFF_ISR = 12'h108;
  localparam logic [11:0] OFF_IPR = 12'h10c;
  localparam logic [11:0] OFF_IMR = 12'h110;
  localparam logic [11:0] OFF_CISR = 12'h114;
  localparam logic [11:0] OFF_IECR = 12'h120;
  localparam logic [11:0] OFF_IDCR = 12'h124;
  localparam logic [11:0] OFF_ICCR = 12'h128;
  localparam logic [11:0] OFF_ISCR = 12'h12c;
  localparam logic [11:0] OFF_EOICR = 12'h130;
  localparam logic [11:0] OFF_SPU = 12'h134;
  localparam logic [11:0] OFF_DCR = 12'h138;
  localparam logic [11:0] OFF_FFER = 12'h140;
  localparam logic [11:0] OFF_FFDR = 12'h144;
  localparam logic [11:0] OFF_FFSR = 12'h148;
  // Field positions
  localparam int SMR_PRIO_LSB = 0;
  localparam int SMR_TRIG_LSB = 5;
  localparam int DCR_PROTECT_BIT = 0;
  localparam int DCR_GLOBAL_MASK_BIT = 1;
  localparam int CISR_FAST_BIT = 0;
  localparam int CISR_NORM_BIT = 1;
  // Values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [1:0] RST_TRIG = 2'h0;
  // Nesting stack
  localparam int STK_DEPTH = 8;
  localparam logic [3:0] STK_FULL = 4'h8;
  localparam logic [3:0] STK_ONE = 4'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Mode word of one source
  typedef struct packed {
    logic [1:0] trig;
    logic [2:0] prio;
  } fifp_smr_type;
  // Captured address phase
  typedef struct packed {
    logic [11:0] off;
    logic wr;
    logic hit;
  } fifp_aph_type;
  // Bus slave phases
  typedef enum logic {BS_IDLE, BS_DATA} fifp_bus_type;
endpackage
`default_nettype wire

// ==== src/fifp_top.sv ====
`default_nettype none
module fifp_top
  import fifp_pkg::*;
#(
  parameter int NUM_SRC = 32,
  parameter logic [NUM_SRC-1:0] EXT_SRC = {{(NUM_SRC-1){1'b0}}, 1'b1}
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [NUM_SRC-1:0] SRC_IN,
  output logic FAST_REQ_N,
  output logic NORMAL_REQ_N,
  output logic WAKEUP_REQ
);
  localparam int IW = $clog2(NUM_SRC);

  // ============================================================
  // Register state
  fifp_smr_type smr [NUM_SRC]; // Mode words
  logic [31:0] svr [NUM_SRC]; // Vector words
  logic [NUM_SRC-1:0] enable; // Mask register contents
  logic [NUM_SRC-1:0] force_status; // Per-source fast forcing
  logic [NUM_SRC-1:0] edge_pend; // Latched edges
  logic [31:0] spu; // Spurious vector
  logic protect_bit; // Protect mode
  logic global_mask_bit; // General mask
  // Nesting stack
  logic [2:0] stk_lvl [STK_DEPTH];
  logic [IW-1:0] stk_num [STK_DEPTH];
  logic [3:0] sp; // Entries in use
  // Memorized interrupt for protect mode
  logic [IW-1:0] held_num;
  logic held_ok; // Low when the memorized one was spurious

  // ============================================================
  // Input synchronisers
  logic [NUM_SRC-1:0] sy1, sy2, sy3; // Three-stage chain
  logic [NUM_SRC-1:0] src_lvl; // Accepted source level
  logic [NUM_SRC-1:0] act_prev; // Active sense one cycle ago

  // Chain: first stage feeds only the second
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
    end else begin
      sy1 <= SRC_IN;
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // A change is taken only when stages two and three agree
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_lvl <= '0;
    end else begin
      src_lvl <= (src_lvl & (sy2 ^ sy3)) | (sy3 & ~(sy2 ^ sy3));
    end
  end

  // ============================================================
  // Trigger decode
  logic [NUM_SRC-1:0] act; // Source in its active sense
  logic [NUM_SRC-1:0] is_edge; // Source is edge triggered
  logic [NUM_SRC-1:0] edge_hit; // Active edge this cycle
  logic [NUM_SRC-1:0] pending; // Pending view

  // External sources invert for codes 00/01, internal never do
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      act[i] = src_lvl[i] ^ (EXT_SRC[i] & ~smr[i].trig[1]);
      is_edge[i] = smr[i].trig[0];
    end
  end

  assign edge_hit = act & ~act_prev & is_edge;
  // Level sources follow the line; edge sources follow the latch.
  // Forcing never touches this, so bit 0 stays source 0's own.
  assign pending = (is_edge & edge_pend) | (~is_edge & act);

  // Previous active sense for edge detection
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_prev <= '0;
    end else begin
      act_prev <= act;
    end
  end

  // ============================================================
  // AHB-Lite slave: one wait state so read data leave a flop
  fifp_bus_type bus_st;
  fifp_aph_type aph;
  logic hit; // Address inside window, word sized and aligned
  logic [31:0] rd_val; // Read mux
  logic wr_s, rd_s; // Data-phase strobes

  assign hit = (HADDR[31:12] == BASE_ADDR[31:12])
    && (HSIZE == HSIZE_WORD) && (HADDR[1:0] == 2'h0);
  assign wr_s = (bus_st == BS_DATA) && aph.hit && aph.wr;
  assign rd_s = (bus_st == BS_DATA) && aph.hit && !aph.wr;

  // Phase tracking, ready and read data
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_st <= BS_IDLE;
      aph <= '0;
      HREADYOUT <= 1'b1;
      HRDATA <= RST_WORD;
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0; // Always OKAY, unmapped included
      unique case (bus_st)
        BS_IDLE: begin
          if (HSEL && HTRANS[1] && HREADY) begin
            aph <= '{off: HADDR[11:0], wr: HWRITE, hit: hit};
            bus_st <= BS_DATA;
            HREADYOUT <= 1'b0;
          end
        end
        BS_DATA: begin
          // Unmapped or write: read data shows zero
          HRDATA <= rd_s ? rd_val : RST_WORD;
          HREADYOUT <= 1'b1;
          bus_st <= BS_IDLE;
        end
      endcase
    end
  end

  // Decoded accesses
  logic w_smr, w_svr, w_iecr, w_idcr, w_iccr, w_iscr, w_eoi;
  logic w_spu, w_dcr, w_ffer, w_ffdr, w_ivr;
  logic r_ivr, r_fvr;
  logic [IW-1:0] idx; // Source index of SMR/SVR access

  assign idx = aph.off[IW+1:2];
  assign w_smr = wr_s && (aph.off[11:7] == OFF_SMR0[11:7]);
  assign w_svr = wr_s && (aph.off[11:7] == OFF_SVR0[11:7]);
  assign w_iecr = wr_s && (aph.off == OFF_IECR);
  assign w_idcr = wr_s && (aph.off == OFF_IDCR);
  assign w_iccr = wr_s && (aph.off == OFF_ICCR);
  assign w_iscr = wr_s && (aph.off == OFF_ISCR);
  assign w_eoi = wr_s && (aph.off == OFF_EOICR);
  assign w_spu = wr_s && (aph.off == OFF_SPU);
  assign w_dcr = wr_s && (aph.off == OFF_DCR);
  assign w_ffer = wr_s && (aph.off == OFF_FFER);
  assign w_ffdr = wr_s && (aph.off == OFF_FFDR);
  assign w_ivr = wr_s && (aph.off == OFF_IVR);
  assign r_ivr = rd_s && (aph.off == OFF_IVR);
  assign r_fvr = rd_s && (aph.off == OFF_FVR);

  // ============================================================
  // Normal priority search
  logic [NUM_SRC-1:0] cand; // Eligible for the normal line
  logic [IW-1:0] best;
  logic [2:0] best_prio;
  logic found;
  logic [2:0] top; // Stack top slot
  logic irq_go; // A source beats the current level

  // Source 0 and forced sources never reach the normal line
  assign cand = pending & enable & ~force_status
    & ~NUM_SRC'(1);
  assign top = 3'(sp - STK_ONE);

  // Descending walk with >= keeps the lowest number on ties
  always_comb begin
    best = '0;
    best_prio = RST_PRIO;
    found = 1'b0;
    for (int i = NUM_SRC - 1; i > 0; i--) begin
      if (cand[i] && (!found || smr[i].prio >= best_prio)) begin
        best = IW'(i);
        best_prio = smr[i].prio;
        found = 1'b1;
      end
    end
  end

  assign irq_go = found && ((sp == 4'h0) || (best_prio > stk_lvl[top]));

  // ============================================================
  // Vector read/write actions
  logic push; // Stack and acknowledge now
  logic [IW-1:0] push_num;
  logic [NUM_SRC-1:0] ack_clr; // Edge clears from acknowledge
  logic [NUM_SRC-1:0] fvr_clr; // Edge clear from fast vector read
  logic [NUM_SRC-1:0] set_v, clr_v;

  // Normal mode: the read itself stacks; a write is ignored.
  // Protect mode: only a write stacks what the read memorized.
  assign push = protect_bit ? (w_ivr && held_ok)
                            : (r_ivr && irq_go);
  assign push_num = protect_bit ? held_num : best;
  // Forced sources are excluded from acknowledge clears
  assign ack_clr = push ? ((NUM_SRC'(1) << push_num) & is_edge
    & ~force_status) : '0;
  // Only an edge-mode, unforced source 0 is cleared by the fast read
  assign fvr_clr = (r_fvr && is_edge[0] && !force_status[0])
    ? NUM_SRC'(1) : '0;
  assign clr_v = ack_clr | fvr_clr
    | (w_iccr ? HWDATA[NUM_SRC-1:0] : '0);
  assign set_v = edge_hit | (w_iscr ? HWDATA[NUM_SRC-1:0] : '0);

  // Edge latches: a new edge wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      edge_pend <= '0;
    end else begin
      edge_pend <= (edge_pend & ~clr_v) | set_v;
    end
  end

  // Memorize the computed interrupt on every IVR read
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      held_num <= '0;
      held_ok <= 1'b0;
    end else if (r_ivr) begin
      held_num <= best;
      held_ok <= irq_go;
    end
  end

  // Nesting stack; a full stack silently drops the push
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sp <= 4'h0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_lvl[i] <= RST_PRIO;
        stk_num[i] <= '0;
      end
    end else if (push && sp < STK_FULL) begin
      stk_lvl[sp[2:0]] <= smr[push_num].prio;
      stk_num[sp[2:0]] <= push_num;
      sp <= sp + STK_ONE;
    end else if (w_eoi && sp != 4'h0) begin
      sp <= sp - STK_ONE; // End of interrupt pops a level
    end
  end

  // ============================================================
  // Configuration registers
  // Mode and vector words
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        smr[i] <= '{trig: RST_TRIG, prio: RST_PRIO};
        svr[i] <= RST_WORD;
      end
    end else begin
      if (w_smr) begin
        // Priority of source 0 is kept only for read-back
        smr[idx].prio <= HWDATA[SMR_PRIO_LSB+:3];
        smr[idx].trig <= HWDATA[SMR_TRIG_LSB+:2];
      end
      if (w_svr) begin
        svr[idx] <= HWDATA;
      end
    end
  end

  // Enable mask, set and cleared by command words
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable <= '0;
    end else if (w_iecr) begin
      enable <= enable | HWDATA[NUM_SRC-1:0];
    end else if (w_idcr) begin
      enable <= enable & ~HWDATA[NUM_SRC-1:0];
    end
  end

  // Fast forcing status
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      force_status <= '0;
    end else if (w_ffer) begin
      force_status <= force_status | HWDATA[NUM_SRC-1:0];
    end else if (w_ffdr) begin
      force_status <= force_status & ~HWDATA[NUM_SRC-1:0];
    end
  end

  // Spurious vector and debug control
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      spu <= RST_WORD;
      protect_bit <= 1'b0;
      global_mask_bit <= 1'b0;
    end else begin
      if (w_spu) begin
        spu <= HWDATA;
      end
      if (w_dcr) begin
        protect_bit <= HWDATA[DCR_PROTECT_BIT];
        global_mask_bit <= HWDATA[DCR_GLOBAL_MASK_BIT];
      end
    end
  end

  // ============================================================
  // Request lines to the core
  logic fast_cond; // Any fast contributor active
  logic norm_cond; // Normal request wanted

  // Source 0 plus every forced, enabled, pending source
  assign fast_cond = (pending[0] & enable[0])
    | (|(pending & enable & force_status));
  assign norm_cond = irq_go;

  // Lines are masked; wake-up ignores the general mask
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAST_REQ_N <= 1'b1;
      NORMAL_REQ_N <= 1'b1;
      WAKEUP_REQ <= 1'b0;
    end else begin
      FAST_REQ_N <= !(fast_cond && !global_mask_bit);
      NORMAL_REQ_N <= !(norm_cond && !global_mask_bit);
      WAKEUP_REQ <= |(pending & enable);
    end
  end

  // ============================================================
  // Read mux; reads with side effects act in the same data cycle
  always_comb begin
    rd_val = RST_WORD;
    if (aph.off[11:7] == OFF_SMR0[11:7]) begin
      rd_val[SMR_PRIO_LSB+:3] = smr[idx].prio;
      rd_val[SMR_TRIG_LSB+:2] = smr[idx].trig;
    end else if (aph.off[11:7] == OFF_SVR0[11:7]) begin
      rd_val = svr[idx];
    end else begin
      unique case (aph.off)
        // Computed vector, or spurious when nothing qualifies
        OFF_IVR: rd_val = irq_go ? svr[best] : spu;
        // Always vector 0, whichever source fired
        OFF_FVR: rd_val = svr[0];
        OFF_ISR: rd_val = (sp != 4'h0) ? 32'(stk_num[top]) : RST_WORD;
        OFF_IPR: rd_val = 32'(pending);
        OFF_IMR: rd_val = 32'(enable);
        OFF_CISR: begin
          rd_val[CISR_FAST_BIT] = !FAST_REQ_N;
          rd_val[CISR_NORM_BIT] = !NORMAL_REQ_N;
        end
        OFF_SPU: rd_val = spu;
        OFF_DCR: begin
          rd_val[DCR_PROTECT_BIT] = protect_bit;
          rd_val[DCR_GLOBAL_MASK_BIT] = global_mask_bit;
        end
        OFF_FFSR: rd_val = 32'(force_status);
        default: rd_val = RST_WORD; // Reserved and write-only
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dv/fifp_top_properties.sv ====
`default_nettype none
// ==========================================
// Port-level checker of the fast interrupt block
module fifp_checker
  import fifp_pkg::*;
#(
  parameter int NUM_SRC = 32
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [NUM_SRC-1:0] SRC_IN,
  input wire logic FAST_REQ_N,
  input wire logic NORMAL_REQ_N,
  input wire logic WAKEUP_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] aoff; // Offset of the transfer in its data phase
  logic acc; // Data phase belongs to a mapped word transfer
  logic awr; // That transfer writes
  logic done; // Data phase completes at this edge
  logic rdd; // A read completes at this edge
  logic [6:0] smr0; // Mirror of the source 0 mode word
  logic [31:0] svr0; // Mirror of the source 0 vector
  logic en0; // Mirror of the fast enable
  logic gm; // Mirror of the general mask
  logic [NUM_SRC-1:0] frc; // Mirror of the forcing bits
  assign done = acc && HREADY;
  assign rdd = done && !awr;
  // ==========================================
  // Address phase capture, only when the bus moves on
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc <= 1'b0;
      aoff <= 12'h0;
      awr <= 1'b0;
    end else if (HREADY) begin
      acc <= HSEL && HTRANS[1] && HSIZE == HSIZE_WORD && HADDR[31:12] == BASE_ADDR[31:12];
      aoff <= HADDR[11:0];
      awr <= HWRITE;
    end
  end
  // Mirrors lag the design by one edge; the assertions allow for it
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      smr0 <= 7'h0;
      svr0 <= 32'h0;
      en0 <= 1'b0;
      gm <= 1'b0;
      frc <= '0;
    end else if (done && awr) begin
      case (aoff)
        OFF_SMR0: smr0 <= HWDATA[6:0];
        OFF_SVR0: svr0 <= HWDATA;
        OFF_IECR: en0 <= en0 | HWDATA[0];
        OFF_IDCR: en0 <= en0 & !HWDATA[0];
        OFF_DCR: gm <= HWDATA[DCR_GLOBAL_MASK_BIT];
        OFF_FFER: frc <= frc | HWDATA[NUM_SRC-1:0];
        OFF_FFDR: frc <= frc & ~HWDATA[NUM_SRC-1:0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  bus_wait_a: assert property (
    HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT && !HRESP)
    else $error("transfer does not finish after one wait state");
  fvr_read_a: assert property (rdd && aoff == OFF_FVR |-> HRDATA == svr0)
    else $error("fast vector read differs from source 0 vector");
  prio_keep_a: assert property (rdd && aoff == OFF_SMR0 |->
    HRDATA[6:5] == smr0[6:5] && HRDATA[2:0] == smr0[2:0])
    else $error("source 0 mode word lost its value");
  mask_bit_a: assert property (rdd && aoff == OFF_IMR |-> HRDATA[0] == en0)
    else $error("mask bit 0 disagrees with fast enable");
  force_stat_a: assert property (rdd && aoff == OFF_FFSR |-> HRDATA[NUM_SRC-1:0] == frc)
    else $error("forcing status disagrees with forcing writes");
  gmask_lines_a: assert property ($past(gm) && gm |-> FAST_REQ_N && NORMAL_REQ_N)
    else $error("request line active under general mask");
  fvr_clear_a: assert property (
    rdd && aoff == OFF_FVR && smr0[5] && frc == '0 |-> ##2 FAST_REQ_N)
    else $error("edge fast request not cleared by vector read");
  fast_off_a: assert property (
    !en0 && !$past(en0) && frc == '0 && $past(frc) == '0 |-> FAST_REQ_N)
    else $error("fast request with source 0 off and nothing forced");
endmodule
bind fifp_top fifp_checker #(.NUM_SRC(NUM_SRC)) chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC_IN(SRC_IN), .FAST_REQ_N(FAST_REQ_N),
  .NORMAL_REQ_N(NORMAL_REQ_N), .WAKEUP_REQ(WAKEUP_REQ));
`default_nettype wire

// ==== dv/fifp_core_model.sv ====
`default_nettype none
// ==========================================
// Core side: counts entries into each handler
module fifp_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fast_req_n,
  input wire logic normal_req_n,
  output int fast_entries,
  output int normal_entries
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_f; // Fast line one edge ago
  logic last_n; // Normal line one edge ago
  // A handler is entered on each falling edge of its line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_f <= 1'b1;
      last_n <= 1'b1;
      fast_entries <= 0;
      normal_entries <= 0;
    end else begin
      last_f <= fast_req_n;
      last_n <= normal_req_n;
      // A line that stays low is one entry, not many
      if (last_f && !fast_req_n) fast_entries <= fast_entries + 1;
      if (last_n && !normal_req_n) normal_entries <= normal_entries + 1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/test_fast_irq_forcing_protect.sv ====
`default_nettype none
// ==========================================
// Self-checking bench of the fast interrupt block
module test_fast_irq_forcing_protect import fifp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, hsel, hwrite, hready, hresp, fast_n, norm_n, wake, rdp, act;
  logic [1:0] htrans, md;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, src, seed, v0, vs, v5, r;
  logic [31:0] exp_q[$]; // Read data noted by the driver, oldest first
  int n_mismatch, checks, n_fe, n_ne;
  // Single slave, so its ready is the bus ready
  fifp_top DUT (
    .REF_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .SRC_IN(src), .FAST_REQ_N(fast_n),
    .NORMAL_REQ_N(norm_n), .WAKEUP_REQ(wake));
  fifp_core_model core (.clk(clk), .rst_n(rst_n), .fast_req_n(fast_n),
    .normal_req_n(norm_n), .fast_entries(n_fe), .normal_entries(n_ne));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic report_err(input string s);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string s);
    checks++;
    if (got !== exp) report_err(s);
  endtask
  // Ready is sampled as it stood before the edge; bounded wait
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      report_err("bus hang");
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] off, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    haddr <= BASE_ADDR | {20'h0, off};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rdp <= !w;
    wait_rdy();
    rdp <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    bus(1'b1, off, d);
  endtask
  task automatic rd(input logic [11:0] off, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, off, 32'h0);
  endtask
  task automatic set_src(input int i, input logic v);
    @(posedge clk);
    src[i] <= v;
  endtask
  // Request latency: sync chain, filter and output register, plus the edge latch for edge sources
  task automatic lines(input logic f, input logic nr);
    repeat (8) @(posedge clk);
    cmp_bit(fast_n, f, "fast line");
    cmp_bit(norm_n, nr, "normal line");
  endtask
  // Watcher: each completed read is matched with the oldest note
  always @(posedge clk) begin
    if (rdp === 1'b1 && hready === 1'b1) begin
      checks++;
      if (hrdata !== exp_q[0] || hresp !== 1'b0) report_err("read data");
      void'(exp_q.pop_front());
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    {rst_n, hsel, hwrite, rdp, act, htrans, md, hsize} = '0;
    {haddr, hwdata, src} = '0;
    seed = 32'hbc29;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    lines(1'b1, 1'b1);
    v0 = rnd();
    vs = rnd();
    v5 = rnd();
    r = rnd();
    wr(OFF_SVR0, v0);
    wr(OFF_SPU, vs);
    wr(OFF_SVR0 + 12'h014, v5);
    wr(OFF_SMR0, r);
    rd(OFF_SMR0, {25'h0, r[6:5], 2'h0, r[2:0]});
    rd(12'h118, 32'h0);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      md = m[1:0];
      act = md[1];
      wr(OFF_IDCR, 32'h1);
      set_src(0, !act);
      wr(OFF_SMR0, {25'h0, md, 5'h0});
      repeat (8) @(posedge clk);
      wr(OFF_ICCR, 32'h1);
      wr(OFF_IECR, 32'h1);
      lines(1'b1, 1'b1);
      set_src(0, act);
      lines(1'b0, 1'b1);
      rd(OFF_FVR, v0);
      lines(md[0], 1'b1);
      set_src(0, !act);
      lines(1'b1, 1'b1);
    end
    rd(OFF_IMR, 32'h1);
    wr(OFF_IDCR, 32'h1);
    set_src(0, 1'b1);
    lines(1'b1, 1'b1);
    rd(OFF_IMR, 32'h0);
    wr(OFF_ICCR, 32'h1);
    $display("test fast modes done");
    wr(12'h014, 32'h23);
    wr(OFF_IECR, 32'h20);
    wr(OFF_FFER, 32'h20);
    rd(OFF_FFSR, 32'h20);
    set_src(5, 1'b1);
    lines(1'b0, 1'b1);
    rd(OFF_IPR, 32'h20);
    rd(OFF_FVR, v0);
    rd(OFF_IVR, vs);
    wr(OFF_EOICR, 32'h0);
    lines(1'b0, 1'b1);
    wr(OFF_ICCR, 32'h20);
    lines(1'b1, 1'b1);
    wr(OFF_ISCR, 32'h20);
    lines(1'b0, 1'b1);
    wr(OFF_ICCR, 32'h20);
    wr(OFF_FFDR, 32'h20);
    rd(OFF_FFSR, 32'h0);
    $display("test forcing done");
    wr(12'h014, 32'h03);
    lines(1'b1, 1'b0);
    rd(OFF_IVR, v5);
    rd(OFF_ISR, 32'h5);
    lines(1'b1, 1'b1);
    wr(OFF_EOICR, 32'h0);
    wr(OFF_DCR, 32'h1);
    rd(OFF_IVR, v5);
    rd(OFF_ISR, 32'h0);
    lines(1'b1, 1'b0);
    wr(OFF_IVR, 32'h0);
    rd(OFF_ISR, 32'h5);
    lines(1'b1, 1'b1);
    wr(OFF_EOICR, 32'h0);
    wr(OFF_DCR, 32'h0);
    wr(OFF_IVR, 32'h0);
    rd(OFF_ISR, 32'h0);
    $display("test protect done");
    wr(OFF_SMR0, 32'h40);
    wr(OFF_IECR, 32'h1);
    lines(1'b0, 1'b0);
    wr(OFF_DCR, 32'h2);
    lines(1'b1, 1'b1);
    cmp_bit(wake, 1'b1, "wake-up");
    wr(OFF_DCR, 32'h0);
    lines(1'b0, 1'b0);
    rd(OFF_CISR, 32'h3);
    cmp_bit(n_fe == 8, 1'b1, "fast entries");
    cmp_bit(n_ne == 4, 1'b1, "normal entries");
    $display("test mask done");
    stop_test();
  end
endmodule
`default_nettype wire
